// ### sfpc_device.sv
// flash device end: framing, buffers, busy and sector protection
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - no new array operation while one runs
// - non-array commands served while busy; array reads not
// - load one buffer while other programs
// - all inbound bits on serial input only
// - sample input rising, change output falling
// - deselected: input ignored, output released
// - select fall starts, rise ends or launches
// - protect pin held min time enables protection
// - pin release drops protection unless command given
// - disable command ignored while pin asserted
// - command protection survives pin release
// - sector protect register resets all-unprotected
// - reset pin low aborts and holds idle
// - resume once reset pin high
// - internal power-on reset, pin may float
// - ready/busy pulled low during self-timed work
// - busy blocks array and used buffer only
// - erase leaves both buffers usable
// - after reset mode 3, output released
// - mode chosen from clock level at select
// - host waits after power-up before commands
// - array group versus non-array group
module sfpc_device #(
    parameter int         DEPTH    = sfpc_pkg::BUF_DEPTH,
    parameter int         BUSY_LEN = sfpc_pkg::BUSY_CYCLES,
    parameter int         PROT_MIN = sfpc_pkg::PROTECT_MIN_CYCLES,
    parameter logic [7:0] ID_CODE  = sfpc_pkg::ID_CODE_DEFAULT
) (
    input  wire logic     clk_in,
    input  wire logic     rst_in,
    sfpc_link_if.dev      link,
    output logic          busy_out,
    output logic          protect_out,
    output logic          mode3_out,
    output logic [7:0]    spr_out
);
    import sfpc_pkg::*;

    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    initial
    begin
        if (DEPTH < 2 || DEPTH > 256 || BUSY_LEN < 1 || BUSY_LEN > 65536 || PROT_MIN < 1 || PROT_MIN > 255)
            $error("sfpc_device: parameter out of range");
    end

    typedef struct packed {
        logic [1:0][DEPTH-1:0][7:0] mem;
        logic [7:0]  spr;
        logic        sck_s1, sck_s2, sck_d;
        logic        cs_s1, cs_s2, cs_d;
        logic        si_s1, si_s2;
        logic        wp_s1, wp_s2;
        logic        rst_s1, rst_s2;
        logic        sel;
        logic        mode3;
        logic [2:0]  bitcnt;
        logic [1:0]  bytecnt;
        logic [7:0]  shin;
        logic [7:0]  shout;
        logic [7:0]  opcode;
        logic [AW-1:0] addr;
        logic        so;
        logic        so_oe;
        logic        busy;
        logic [15:0] busy_cnt;
        logic [1:0]  busy_buf;
        logic        prot_flag;
        logic [7:0]  wp_cnt;
        logic        prot_eff;
    } sfpc_dst_t;

    sfpc_dst_t s;
    sfpc_dst_t n;

    logic       sck_rise;
    logic       sck_fall;
    logic       cs_fall;
    logic       cs_rise;
    logic [7:0] rx_byte;
    logic       bsel;

    function automatic logic f_buf2(input logic [7:0] op);
        f_buf2 = (op == OP_BUF2_RD) || (op == OP_BUF2_WR) || (op == OP_PROG2) || (op == OP_PROG2_NE)
                 || (op == OP_XFER2);
    endfunction : f_buf2

    function automatic logic f_is_prog(input logic [7:0] op);
        f_is_prog = (op == OP_PROG1) || (op == OP_PROG2) || (op == OP_PROG1_NE) || (op == OP_PROG2_NE)
                    || (op == OP_PAGE_ERASE) || (op == OP_BLOCK_ERASE);
    endfunction : f_is_prog

    // edges of the synchronised serial clock and chip select
    assign sck_rise = s.sck_s2 & ~s.sck_d;
    assign sck_fall = ~s.sck_s2 & s.sck_d;
    assign cs_fall  = s.cs_d & ~s.cs_s2;
    assign cs_rise  = ~s.cs_d & s.cs_s2;
    // every inbound bit comes from serial input
    assign rx_byte  = {s.shin[6:0], s.si_s2};
    assign bsel     = f_buf2(s.opcode);

    always_comb
    begin
        n        = s;
        n.sck_s1 = link.sck;
        n.sck_s2 = s.sck_s1;
        n.sck_d  = s.sck_s2;
        n.cs_s1  = link.cs_n;
        n.cs_s2  = s.cs_s1;
        n.cs_d   = s.cs_s2;
        n.si_s1  = link.si;
        n.si_s2  = s.si_s1;
        n.wp_s1  = link.wp_n;
        n.wp_s2  = s.wp_s1;
        n.rst_s1 = link.reset_n;
        n.rst_s2 = s.rst_s1;

        if (s.busy)
        begin
            if (s.busy_cnt == 16'h0000)
            begin
                n.busy     = 1'b0;
                n.busy_buf = 2'b00;
            end
            else
                n.busy_cnt = s.busy_cnt - 16'h0001;
        end

        // count how long the protect pin has been low
        if (!s.wp_s2)
        begin
            if (s.wp_cnt != 8'(PROT_MIN))
                n.wp_cnt = s.wp_cnt + 8'h01;
        end
        else
            n.wp_cnt = 8'h00;

        // clock idle level at select picks mode 0 or 3
        if (cs_fall)
        begin
            n.sel     = 1'b1;
            n.mode3   = s.sck_s2;
            n.bitcnt  = 3'h0;
            n.bytecnt = 2'h0;
            n.shout   = 8'h00;
            n.opcode  = OP_NONE;
            n.so_oe   = 1'b1;
        end
        // deselect releases the output and stops shifting
        else if (cs_rise)
        begin
            n.sel   = 1'b0;
            n.so_oe = 1'b0;
            // array operation refused while another runs
            // rising select launches the self-timed work
            if (s.sel && !s.busy && (f_is_prog(s.opcode) || s.opcode == OP_XFER1 || s.opcode == OP_XFER2
                || s.opcode == OP_SPR_PROG))
            begin
                // effective protection blocks guarded program or erase
                if (!(f_is_prog(s.opcode) && s.prot_eff && s.spr != 8'h00))
                begin
                    n.busy     = 1'b1;
                    n.busy_cnt = 16'(BUSY_LEN - 1);
                    // only the buffer the operation uses is locked, none for erase
                    if (s.opcode == OP_PAGE_ERASE || s.opcode == OP_BLOCK_ERASE)
                        n.busy_buf = 2'b00;
                    else if (s.opcode == OP_SPR_PROG)
                    begin
                        n.busy_buf = 2'b01;
                        n.spr      = s.mem[0][0];
                    end
                    else
                        n.busy_buf = bsel ? 2'b10 : 2'b01;
                end
            end
        end
        else if (s.sel && sck_rise)
        begin
            n.shin   = rx_byte;
            n.bitcnt = s.bitcnt + 3'h1;
            if (s.bitcnt == 3'h7)
            begin
                if (s.bytecnt != 2'h2)
                    n.bytecnt = s.bytecnt + 2'h1;
                if (s.bytecnt == 2'h0)
                begin
                    n.opcode = rx_byte;
                    case (rx_byte)
                        // status and identity still answer while busy
                        OP_STATUS:   n.shout = {~s.busy, 5'h00, s.prot_eff, s.mode3};
                        OP_ID:       n.shout = ID_CODE;
                        OP_PAGE_RD, OP_CONT_RD:
                        begin
                            if (s.busy)
                                n.opcode = OP_NONE;
                        end
                        // enable sets the flag at any pin level
                        OP_PROT_EN:  n.prot_flag = 1'b1;
                        // disable ignored while protect pin low
                        OP_PROT_DIS:
                        begin
                            if (s.wp_s2)
                                n.prot_flag = 1'b0;
                        end
                        default:     n.shout = 8'h00;
                    endcase
                end
                else
                begin
                    case (s.opcode)
                        OP_STATUS:   n.shout = {~s.busy, 5'h00, s.prot_eff, s.mode3};
                        // a locked buffer reads zero and ignores writes
                        OP_BUF1_RD, OP_BUF2_RD:
                        begin
                            if (s.bytecnt == 2'h1)
                            begin
                                n.shout = s.busy_buf[bsel] ? 8'h00 : s.mem[bsel][rx_byte[AW-1:0]];
                                n.addr  = rx_byte[AW-1:0] + AW'(1);
                            end
                            else
                            begin
                                n.shout = s.busy_buf[bsel] ? 8'h00 : s.mem[bsel][s.addr];
                                n.addr  = s.addr + AW'(1);
                            end
                        end
                        OP_BUF1_WR, OP_BUF2_WR:
                        begin
                            if (s.bytecnt == 2'h1)
                                n.addr = rx_byte[AW-1:0];
                            else
                            begin
                                if (!s.busy_buf[bsel])
                                    n.mem[bsel][s.addr] = rx_byte;
                                n.addr = s.addr + AW'(1);
                            end
                        end
                        default:     n.shout = 8'h00;
                    endcase
                end
            end
        end
        // output changes on the falling clock edge
        else if (s.sel && sck_fall)
        begin
            n.so    = s.shout[7];
            n.shout = {s.shout[6:0], 1'b0};
        end

        // reset pin low aborts everything and holds idle
        // leaving this branch resumes normal decoding
        // mode 3 and released output; a fresh select fall is needed
        if (!s.rst_s2)
        begin
            n.sel      = 1'b0;
            n.mode3    = 1'b1;
            n.so       = 1'b0;
            n.so_oe    = 1'b0;
            n.busy     = 1'b0;
            n.busy_cnt = 16'h0000;
            n.busy_buf = 2'b00;
            n.bitcnt   = 3'h0;
            n.bytecnt  = 2'h0;
            n.opcode   = OP_NONE;
            n.shout    = 8'h00;
        end
        // pin held long enough or command flag
        n.prot_eff = n.prot_flag | (n.wp_cnt == 8'(PROT_MIN));
    end

    // power-on reset is the asynchronous reset; pin syncs start released
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            s        <= '0;
            s.spr    <= SPR_RESET;
            s.mode3  <= 1'b1;
            s.cs_s1  <= 1'b1;
            s.cs_s2  <= 1'b1;
            s.cs_d   <= 1'b1;
            s.wp_s1  <= 1'b1;
            s.wp_s2  <= 1'b1;
            s.rst_s1 <= 1'b1;
            s.rst_s2 <= 1'b1;
        end
        else
            s <= n;
    end

    assign link.so     = s.so;
    assign link.so_oe  = s.so_oe;
    assign link.rdy_o  = 1'b0;
    // open-drain busy pulled low for the whole operation
    assign link.rdy_oe = s.busy;
    assign busy_out    = s.busy;
    assign protect_out = s.prot_eff;
    assign mode3_out   = s.mode3;
    assign spr_out     = s.spr;
endmodule : sfpc_device
`default_nettype wire

// ### sfpc_host.sv
// host end: Avalon-MM registers driving the serial link in mode 0
`timescale 1ns/1ps
`default_nettype none
module sfpc_host #(
    parameter int PU_CYCLES = sfpc_pkg::POWERUP_CYCLES,
    parameter int HALF      = sfpc_pkg::SCK_HALF
) (
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    input  wire logic [1:0]  avs_address_in,
    input  wire logic        avs_read_in,
    input  wire logic        avs_write_in,
    input  wire logic [31:0] avs_writedata_in,
    output logic [31:0]      avs_readdata_out,
    output logic             avs_waitrequest_out,
    sfpc_link_if.host        link
);
    import sfpc_pkg::*;

    initial
    begin
        if (HALF < 4 || HALF > 255 || PU_CYCLES < 1 || PU_CYCLES >= (1 << 20))
            $error("sfpc_host: parameter out of range");
    end

    typedef struct packed {
        sfpc_hstate_t st;
        logic         sck, cs_n, si, wp_n, rst_n;
        logic         so_s1, so_s2, rdy_s1, rdy_s2;
        logic [7:0]   div;
        logic [2:0]   bitn;
        logic [7:0]   tx;
        logic [7:0]   rx;
        logic         last;
        logic [19:0]  pu_cnt;
        logic         pu_done;
        logic         wr;
        logic [31:0]  rdata;
    } sfpc_hst_t;

    sfpc_hst_t s;
    sfpc_hst_t n;
    logic      tick;
    logic      engaged;

    assign tick    = (s.div == 8'(HALF - 1));
    assign engaged = (s.st != H_IDLE);

    always_comb
    begin
        n        = s;
        n.so_s1  = link.so_line;
        n.so_s2  = s.so_s1;
        n.rdy_s1 = link.rdy_line;
        n.rdy_s2 = s.rdy_s1;
        n.div    = (engaged && !tick) ? s.div + 8'h01 : 8'h00;
        // commands refused until the power-up wait has passed
        if (!s.pu_done)
        begin
            if (s.pu_cnt == 20'(PU_CYCLES - 1))
                n.pu_done = 1'b1;
            else
                n.pu_cnt = s.pu_cnt + 20'h00001;
        end

        ////////////////////////////////////////////////////////////
        // one wait state per access; a frame write waits for the engine
        n.wr = 1'b1;
        if ((avs_read_in || avs_write_in) && s.wr)
        begin
            if (!(avs_write_in && avs_address_in == REG_TX && engaged))
                n.wr = 1'b0;
            if (avs_address_in == REG_STATUS)
                n.rdata = {29'h0, s.pu_done, s.rdy_s2, engaged};
            else if (avs_address_in == REG_RX)
                n.rdata = {24'h0, s.rx};
            else if (avs_address_in == REG_PINS)
                n.rdata = {30'h0, s.rst_n, s.wp_n};
            else
                n.rdata = 32'h0;
        end

        ////////////////////////////////////////////////////////////
        case (s.st)
            H_IDLE:
            begin
                if (avs_write_in && !s.wr && avs_address_in == REG_PINS)
                begin
                    n.wp_n  = avs_writedata_in[0];
                    n.rst_n = avs_writedata_in[1];
                end
                // opcode, address and data all leave on serial input
                else if (avs_write_in && !s.wr && avs_address_in == REG_TX && s.pu_done)
                begin
                    n.tx   = avs_writedata_in[7:0];
                    n.last = avs_writedata_in[TX_LAST_BIT];
                    n.si   = avs_writedata_in[7];
                    n.bitn = 3'h0;
                    // select falls to open a frame
                    if (s.cs_n)
                    begin
                        n.cs_n = 1'b0;
                        n.st   = H_SETUP;
                    end
                    else
                        n.st = H_LOW;
                end
            end
            H_SETUP: if (tick) n.st = H_LOW;
            // device samples on rise, host samples late in the high phase
            H_LOW:
            begin
                if (tick)
                begin
                    n.sck = 1'b1;
                    n.st  = H_HIGH;
                end
            end
            H_HIGH:
            begin
                if (tick)
                begin
                    n.sck  = 1'b0;
                    n.rx   = {s.rx[6:0], s.so_s2};
                    n.tx   = {s.tx[6:0], 1'b0};
                    n.si   = s.tx[6];
                    n.bitn = s.bitn + 3'h1;
                    if (s.bitn != 3'h7)
                        n.st = H_LOW;
                    else
                        n.st = s.last ? H_END : H_IDLE;
                end
            end
            // select rises to end or launch the operation
            H_END:
            begin
                if (tick)
                begin
                    n.cs_n = 1'b1;
                    n.st   = H_GAP;
                end
            end
            default: if (tick) n.st = H_IDLE;
        endcase
    end

    // reset pin driven high whenever not commanded low
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            s       <= '0;
            s.cs_n  <= 1'b1;
            s.wp_n  <= 1'b1;
            s.rst_n <= 1'b1;
            s.wr    <= 1'b1;
            s.st    <= H_IDLE;
        end
        else
            s <= n;
    end

    assign link.sck            = s.sck;
    assign link.cs_n           = s.cs_n;
    assign link.si             = s.si;
    assign link.wp_n           = s.wp_n;
    assign link.reset_n        = s.rst_n;
    assign avs_readdata_out    = s.rdata;
    assign avs_waitrequest_out = s.wr;
endmodule : sfpc_host
`default_nettype wire

// ### sfpc_link_if.sv
// serial link between host controller and flash device, wire levels resolved here
`timescale 1ns/1ps
`default_nettype none
interface sfpc_link_if;
    logic sck;
    logic cs_n;
    logic si;
    logic so;
    logic so_oe;
    logic wp_n;
    logic reset_n;
    logic rdy_o;
    logic rdy_oe;
    logic so_line;
    logic rdy_line;
    // released lines float high through pull-ups
    assign so_line  = so_oe ? so : 1'b1;
    assign rdy_line = rdy_oe ? rdy_o : 1'b1;
    modport dev  (input sck, cs_n, si, wp_n, reset_n, output so, so_oe, rdy_o, rdy_oe);
    modport host (output sck, cs_n, si, wp_n, reset_n, input so_line, rdy_line);
endinterface : sfpc_link_if
`default_nettype wire

// ### sfpc_link_properties.sv
// concurrent checks on the serial link between host and device ends
`timescale 1ns/1ps
`default_nettype none
module sfpc_link_properties #(
    parameter int BUSY_LEN = 20
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic sck,
    input wire logic cs_n,
    input wire logic so,
    input wire logic so_oe,
    input wire logic wp_n,
    input wire logic reset_n,
    input wire logic rdy_o,
    input wire logic rdy_oe,
    input wire logic busy_out,
    input wire logic protect_out,
    input wire logic mode3_out
);
    int bcnt_r;
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    ////////////////////////////////////////////////////////////////////////
    // busy length counted here, far beyond what a repetition may unroll
    always_ff @(posedge clk_in or posedge rst_in)
        if (rst_in)
            bcnt_r <= 0;
        else
            bcnt_r <= busy_out ? bcnt_r + 1 : 0;
    ////////////////////////////////////////////////////////////////////////
    AST_SO_RELEASED:
    assert property (cs_n [*4] |-> !so_oe) else $error("output driven while deselected");
    AST_RDY_FOLLOWS_BUSY:
    assert property (rdy_oe == busy_out && rdy_o == 1'b0) else $error("ready line not tied to busy");
    AST_BUSY_LENGTH:
    assert property (disable iff (rst_in || !reset_n) $fell(busy_out) |-> bcnt_r == BUSY_LEN)
        else $error("busy length wrong");
    AST_BUSY_LAUNCH:
    assert property ($rose(busy_out) |-> cs_n && $past(cs_n, 8) == 1'b0) else $error("busy without select rise");
    AST_RESET_PIN:
    assert property (!reset_n [*5] |-> !busy_out && !so_oe && mode3_out) else $error("reset pin not obeyed");
    AST_PROTECT_PIN:
    assert property (!wp_n [*8] |-> protect_out) else $error("protect pin held but unprotected");
    AST_PROTECT_DROP:
    assert property ($fell(protect_out) |-> wp_n) else $error("protection dropped while pin asserted");
    AST_MODE_SELECT:
    assert property (disable iff (rst_in || !reset_n) $fell(cs_n) |-> ##[1:6] !mode3_out)
        else $error("mode 0 not chosen at select");
    AST_SO_ON_LOW:
    assert property (so_oe && $past(so_oe) && $changed(so) |-> !sck) else $error("output changed with clock high");
endmodule : sfpc_link_properties
`default_nettype wire

// ### sfpc_pkg.sv
// shared constants, opcodes and host register map for the serial flash pin control
`default_nettype none
package sfpc_pkg;
    localparam int CLK_HZ                     = 25_000_000;
    localparam int CLK_PERIOD_NS              = 40;
    localparam int POWERUP_WAIT_MS            = 20;
    localparam int POWERUP_CYCLES             = POWERUP_WAIT_MS * (CLK_HZ / 1000);
    localparam int PROTECT_ASSERT_MIN_TIME_NS = 100;
    localparam int PROTECT_MIN_CYCLES         =
        (PROTECT_ASSERT_MIN_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BUSY_CYCLES                = 256;
    localparam int BUF_DEPTH                  = 16;
    localparam int SCK_HALF                   = 4;
    // identity byte value is arbitrary
    localparam logic [7:0] ID_CODE_DEFAULT    = 8'h5A;
    localparam logic [7:0] SPR_RESET          = 8'h00;

    localparam logic [7:0] OP_NONE        = 8'h00;
    localparam logic [7:0] OP_STATUS      = 8'hD7;
    localparam logic [7:0] OP_ID          = 8'h9F;
    localparam logic [7:0] OP_BUF1_RD     = 8'hD4;
    localparam logic [7:0] OP_BUF2_RD     = 8'hD6;
    localparam logic [7:0] OP_BUF1_WR     = 8'h84;
    localparam logic [7:0] OP_BUF2_WR     = 8'h87;
    localparam logic [7:0] OP_PROG1       = 8'h83;
    localparam logic [7:0] OP_PROG2       = 8'h86;
    localparam logic [7:0] OP_PROG1_NE    = 8'h88;
    localparam logic [7:0] OP_PROG2_NE    = 8'h89;
    localparam logic [7:0] OP_PAGE_ERASE  = 8'h81;
    localparam logic [7:0] OP_BLOCK_ERASE = 8'h50;
    localparam logic [7:0] OP_XFER1       = 8'h53;
    localparam logic [7:0] OP_XFER2       = 8'h55;
    localparam logic [7:0] OP_PAGE_RD     = 8'hD2;
    localparam logic [7:0] OP_CONT_RD     = 8'hE8;
    localparam logic [7:0] OP_PROT_EN     = 8'h3D;
    localparam logic [7:0] OP_PROT_DIS    = 8'h2A;
    localparam logic [7:0] OP_SPR_PROG    = 8'hFC;

    localparam logic [1:0] REG_TX     = 2'h0;
    localparam logic [1:0] REG_STATUS = 2'h1;
    localparam logic [1:0] REG_RX     = 2'h2;
    localparam logic [1:0] REG_PINS   = 2'h3;
    localparam int         TX_LAST_BIT = 8;

    typedef enum logic [2:0] {H_IDLE, H_SETUP, H_LOW, H_HIGH, H_END, H_GAP} sfpc_hstate_t;
endpackage : sfpc_pkg
`default_nettype wire

// ### sfpc_tb_top.sv
// self-checking bench joining host and device ends
`timescale 1ns/1ps
`default_nettype none
module sfpc_tb_top;
    import sfpc_pkg::*;
    localparam int BLEN = 4000;
    logic clk_in = 1'b0, rst_in = 1'b1, av_rd = 1'b0, av_wr = 1'b0, wreq, busy, prot, mode3;
    logic [1:0]  av_addr = 2'h0;
    logic [31:0] av_wd = 32'h0, rdata;
    logic [7:0]  spr;
    int fails = 0, num_checks = 0, cyc = 0;
    sfpc_link_if u_link();
    sfpc_host #(.PU_CYCLES(20)) u_sfpc_host (.clk_in(clk_in), .rst_in(rst_in), .avs_address_in(av_addr),
        .avs_read_in(av_rd), .avs_write_in(av_wr), .avs_writedata_in(av_wd), .avs_readdata_out(rdata),
        .avs_waitrequest_out(wreq), .link(u_link.host));
    sfpc_device #(.BUSY_LEN(BLEN)) u_sfpc_device (.clk_in(clk_in), .rst_in(rst_in), .link(u_link.dev),
        .busy_out(busy), .protect_out(prot), .mode3_out(mode3), .spr_out(spr));
    sfpc_link_properties #(.BUSY_LEN(BLEN)) u_props (.clk_in(clk_in), .rst_in(rst_in), .sck(u_link.sck),
        .cs_n(u_link.cs_n), .so(u_link.so), .so_oe(u_link.so_oe), .wp_n(u_link.wp_n),
        .reset_n(u_link.reset_n), .rdy_o(u_link.rdy_o), .rdy_oe(u_link.rdy_oe), .busy_out(busy),
        .protect_out(prot), .mode3_out(mode3));
    always #20 clk_in = ~clk_in;
    ////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : report_and_stop
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // request held until waitrequest is seen low at a rising edge
    task automatic av(input logic [1:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
        @(posedge clk_in);
        av_addr <= a;
        av_rd   <= !w;
        av_wr   <= w;
        av_wd   <= d;
        do @(posedge clk_in); while (wreq !== 1'b0);
        q = rdata;
        av_rd <= 1'b0;
        av_wr <= 1'b0;
    endtask : av
    task automatic wait_bit(input int idx, input logic v);
        logic [31:0] q;
        do av(REG_STATUS, 1'b0, 32'h0, q); while (q[idx] !== v);
    endtask : wait_bit
    // one frame, last byte ends it; returns the byte read during the last byte
    task automatic frm(input logic [7:0] b[$], output logic [7:0] r);
        logic [31:0] q;
        for (int i = 0; i < b.size(); i++)
        begin
            av(REG_TX, 1'b1, {23'h0, i == b.size() - 1, b[i]}, q);
            wait_bit(0, 1'b0);
        end
        av(REG_RX, 1'b0, 32'h0, q);
        r = q[7:0];
    endtask : frm
    ////////////////////////////////////////////////////////////////////////
    task automatic t_start;
        logic [7:0] r;
        chk(mode3, 1'b1);
        chk(u_link.so_oe, 1'b0);
        chk(spr, SPR_RESET);
        wait_bit(2, 1'b1);
        frm({OP_STATUS, 8'h00}, r);
        chk(r, 8'h80);
        frm({OP_ID, 8'h00}, r);
        chk(r, ID_CODE_DEFAULT);
    endtask : t_start
    task automatic t_busy;
        logic [7:0] r;
        logic [31:0] q;
        frm({OP_BUF1_WR, 8'h00, 8'h11}, r);
        frm({OP_PROG1}, r);
        av(REG_STATUS, 1'b0, 32'h0, q);
        chk(q[1], 1'b0);
        frm({OP_BUF2_WR, 8'h01, 8'hA5}, r);
        frm({OP_BUF2_RD, 8'h01, 8'h00}, r);
        chk(r, 8'hA5);
        frm({OP_BUF1_RD, 8'h00, 8'h00}, r);
        chk(r, 8'h00);
        frm({OP_STATUS, 8'h00}, r);
        chk(r, 8'h00);
        frm({OP_PAGE_RD, 8'h00, 8'h00}, r);
        chk(r, 8'h00);
        frm({OP_PAGE_ERASE}, r);
        wait_bit(1, 1'b1);
        frm({OP_STATUS, 8'h00}, r);
        chk(r, 8'h80);
        frm({OP_BUF1_RD, 8'h00, 8'h00}, r);
        chk(r, 8'h11);
    endtask : t_busy
    task automatic t_protect;
        logic [7:0] r;
        logic [31:0] q;
        av(REG_PINS, 1'b1, 32'h2, q);
        frm({OP_STATUS, 8'h00}, r);
        chk(r, 8'h82);
        av(REG_PINS, 1'b1, 32'h3, q);
        frm({OP_STATUS, 8'h00}, r);
        chk(r, 8'h80);
        av(REG_PINS, 1'b1, 32'h2, q);
        frm({OP_PROT_EN}, r);
        frm({OP_PROT_DIS}, r);
        av(REG_PINS, 1'b1, 32'h3, q);
        frm({OP_STATUS, 8'h00}, r);
        chk(r, 8'h82);
        frm({OP_PROT_DIS}, r);
        frm({OP_STATUS, 8'h00}, r);
        chk(r, 8'h80);
        chk(prot, 1'b0);
    endtask : t_protect
    task automatic t_reset_pin;
        logic [7:0] r;
        logic [31:0] q;
        frm({OP_BLOCK_ERASE}, r);
        frm({OP_BUF1_RD, 8'h00, 8'h00}, r);
        chk(r, 8'h11);
        av(REG_PINS, 1'b1, 32'h1, q);
        av(REG_STATUS, 1'b0, 32'h0, q);
        av(REG_STATUS, 1'b0, 32'h0, q);
        av(REG_STATUS, 1'b0, 32'h0, q);
        chk(q[1], 1'b1);
        chk(busy, 1'b0);
        chk(mode3, 1'b1);
        av(REG_PINS, 1'b1, 32'h3, q);
        frm({OP_STATUS, 8'h00}, r);
        chk(r, 8'h80);
        frm({OP_SPR_PROG}, r);
        wait_bit(1, 1'b1);
        chk(spr, 8'h11);
        av(REG_PINS, 1'b1, 32'h2, q);
        frm({OP_PROG1}, r);
        av(REG_STATUS, 1'b0, 32'h0, q);
        chk(q[1], 1'b1);
        chk(busy, 1'b0);
    endtask : t_reset_pin
    ////////////////////////////////////////////////////////////////////////
    // cycle ceiling well above the longest expected run
    always @(posedge clk_in)
    begin
        cyc++;
        if (cyc == 40000)
        begin
            fails++;
            report_and_stop();
        end
    end
    initial
    begin
        repeat (12) @(posedge clk_in);
        rst_in <= 1'b0;
        @(posedge clk_in);
        t_start();
        t_busy();
        t_protect();
        t_reset_pin();
        report_and_stop();
    end
endmodule : sfpc_tb_top
`default_nettype wire
